// ### src/dccal_consts.vh
// Purpose: constants for the per-channel code calibration datapath
// Assumes: plain register port, 50 MHz clock
// Notes:   addresses are {kind, channel}
`ifndef DCCAL_CONSTS_VH
`define DCCAL_CONSTS_VH
`define DCCAL_NUM_CH        32
`define DCCAL_CH_BITS       5
`define DCCAL_CODE_W        14
`define DCCAL_GAIN_W        13
`define DCCAL_ADDR_W        8
`define DCCAL_KIND_LSB      5
`define DCCAL_KIND_INPUT    3'h0
`define DCCAL_KIND_GAIN     3'h1
`define DCCAL_KIND_OFFSET   3'h2
`define DCCAL_KIND_CONV     3'h3
`define DCCAL_KIND_OUT      3'h4
`define DCCAL_KIND_STATUS   3'h5
`define DCCAL_RST_INPUT     14'h2000
`define DCCAL_RST_CONV      14'h2000
`define DCCAL_RST_GAIN      13'h1fff
`define DCCAL_RST_OFFSET    14'h2000
`define DCCAL_MID           16'sh2000
`define DCCAL_FULL          14'h3fff
`define DCCAL_GAIN_SHIFT    13
`define DCCAL_GROUP_SIZE    8
`define DCCAL_GROUP_REF1    6
`endif

// ### src/dccal_datapath.v
// Purpose: 32-channel gain/offset calibration of converter codes
// Assumes: single clock mclk_i, async active-low reset, load_outputs_n_i from a pin
// Notes:   one channel is computed per cycle from a pending mask
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "dccal_consts.vh"
module dccal_datapath #(
  parameter NUM_CH = `DCCAL_NUM_CH
)(
  // clock and reset
  input  wire                          mclk_i,
  input  wire                          rst_n_i,
  // register port
  input  wire [`DCCAL_ADDR_W-1:0]      addr_i,
  input  wire [15:0]                   wdata_i,
  input  wire                          wr_i,
  input  wire                          rd_i,
  output reg  [15:0]                   rdata_o,
  // load strobe pin and status
  input  wire                          load_outputs_n_i,
  output wire                          busy_n_o,
  // converter codes presented to the string converters
  output wire [NUM_CH*`DCCAL_CODE_W-1:0] out_code_o,
  output wire [NUM_CH-1:0]             ref_set2_o
);

  // per-channel register files
  reg  [`DCCAL_CODE_W-1:0]   input_code_ff     [0:NUM_CH-1];
  reg  [`DCCAL_GAIN_W-1:0]   gain_ff           [0:NUM_CH-1];
  reg  [`DCCAL_CODE_W-1:0]   offset_ff         [0:NUM_CH-1];
  reg  [`DCCAL_CODE_W-1:0]   converter_code_ff [0:NUM_CH-1];
  reg  [`DCCAL_CODE_W-1:0]   out_code_ff       [0:NUM_CH-1];

  // scheduler: one-hot state, pending mask, selected channel
  localparam [1:0]           S_IDLE = 2'b01;
  localparam [1:0]           S_CALC = 2'b10;
  reg  [1:0]                 state_ff;
  reg  [1:0]                 nxt_state;
  reg  [NUM_CH-1:0]          pend_ff;
  reg  [NUM_CH-1:0]          nxt_pend;
  reg  [`DCCAL_CH_BITS-1:0]  sel_ff;

  // load strobe synchroniser and stored request
  reg                        ld_meta_ff;
  reg                        ld_sync_ff;
  reg                        ld_prev_ff;
  reg                        ld_req_ff;
  reg                        nxt_ld_req;

  // read data
  reg  [15:0]                nxt_rdata;

  // address decode: kind in the upper bits, channel in the lower
  wire [2:0]                 kind      = addr_i[`DCCAL_KIND_LSB+2:`DCCAL_KIND_LSB];
  wire [`DCCAL_CH_BITS-1:0]  ch        = addr_i[`DCCAL_CH_BITS-1:0];
  wire                       is_input  = (kind == `DCCAL_KIND_INPUT);
  wire                       is_gain   = (kind == `DCCAL_KIND_GAIN);
  wire                       is_offset = (kind == `DCCAL_KIND_OFFSET);
  wire                       wr_input  = wr_i && is_input;
  wire                       wr_gain   = wr_i && is_gain;
  wire                       wr_offset = wr_i && is_offset;
  wire                       wr_cal    = wr_input || wr_gain || wr_offset;
  wire [NUM_CH-1:0]          wr_onehot = wr_cal ? ({{(NUM_CH-1){1'b0}}, 1'b1} << ch) : {NUM_CH{1'b0}};

  // busy and load qualification
  wire                       in_calc   = state_ff[1];
  wire                       any_pend  = |pend_ff;
  wire                       busy      = any_pend || in_calc;
  wire                       ld_low    = !ld_sync_ff;
  wire                       ld_fall   = ld_prev_ff && !ld_sync_ff;
  wire                       copy_out  = !busy && (ld_req_ff || ld_fall || ld_low);

  // busy_n_o is low while any channel waits or is in calculation
  assign busy_n_o = !busy;

  // lowest pending channel
  reg  [`DCCAL_CH_BITS-1:0]  pick;
  integer                    k;
  always @*
  begin
    pick = {`DCCAL_CH_BITS{1'b0}};
    for (k = NUM_CH-1; k >= 0; k = k - 1)
      if (pend_ff[k])
        pick = k[`DCCAL_CH_BITS-1:0];
  end

  wire [NUM_CH-1:0]          pick_onehot = any_pend ? ({{(NUM_CH-1){1'b0}}, 1'b1} << pick) : {NUM_CH{1'b0}};

  // next pending mask; a write in the same cycle wins over the clear
  always @*
  begin
    nxt_pend = pend_ff & ~pick_onehot;
    nxt_pend = nxt_pend | wr_onehot;
  end

  // one channel enters the calculation stage per cycle
  always @*
  begin
    nxt_state = S_IDLE;
    case (state_ff)
      S_IDLE:
        if (any_pend)
          nxt_state = S_CALC;
        else
          nxt_state = S_IDLE;
      S_CALC:
        if (any_pend)
          nxt_state = S_CALC;
        else
          nxt_state = S_IDLE;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  // scheduler state register
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= S_IDLE;
    else
      state_ff <= nxt_state;
  end

  // pending channels
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pend_ff <= {NUM_CH{1'b0}};
    else
      pend_ff <= nxt_pend;
  end

  // channel being calculated
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sel_ff <= {`DCCAL_CH_BITS{1'b0}};
    else
      sel_ff <= pick;
  end

  // transfer function on the selected channel
  wire [`DCCAL_CODE_W-1:0]   sel_input  = input_code_ff[sel_ff];
  wire [`DCCAL_GAIN_W-1:0]   sel_gain   = gain_ff[sel_ff];
  wire [`DCCAL_CODE_W-1:0]   sel_offset = offset_ff[sel_ff];
  wire [`DCCAL_GAIN_W:0]     gain_p1    = {1'b0, sel_gain} + 14'h0001;
  wire [27:0]                prod       = gain_p1 * sel_input;
  wire signed [15:0]         scaled     = {1'b0, prod[`DCCAL_GAIN_SHIFT+14:`DCCAL_GAIN_SHIFT]};
  wire signed [15:0]         offset_s   = {2'b00, sel_offset};
  wire signed [15:0]         sum        = scaled + offset_s - `DCCAL_MID;
  wire                       underflow  = sum[15];
  wire                       overflow   = !sum[15] && sum[14];
  wire [`DCCAL_CODE_W-1:0]   clamped    = underflow ? {`DCCAL_CODE_W{1'b0}} :
                                          overflow  ? `DCCAL_FULL :
                                          sum[`DCCAL_CODE_W-1:0];

  // two-flop synchroniser on the load pin
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ld_meta_ff <= 1'b1;
      ld_sync_ff <= 1'b1;
    end
    else
    begin
      ld_meta_ff <= load_outputs_n_i;
      ld_sync_ff <= ld_meta_ff;
    end
  end

  // previous synchronised level; resets to the idle level to avoid a false edge
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ld_prev_ff <= 1'b1;
    else
      ld_prev_ff <= ld_sync_ff;
  end

  // a load seen while busy is kept until busy ends
  always @*
  begin
    nxt_ld_req = ld_req_ff;
    if (!busy)
      nxt_ld_req = 1'b0;
    else if (ld_fall || ld_low)
      nxt_ld_req = 1'b1;
  end

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ld_req_ff <= 1'b0;
    else
      ld_req_ff <= nxt_ld_req;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : g_ch
      reg  [`DCCAL_CODE_W-1:0] nxt_input;
      reg  [`DCCAL_GAIN_W-1:0] nxt_gain;
      reg  [`DCCAL_CODE_W-1:0] nxt_offset;
      reg  [`DCCAL_CODE_W-1:0] nxt_conv;
      reg  [`DCCAL_CODE_W-1:0] nxt_out;
      // per-channel write decode
      wire                     hit       = (ch == g);
      wire                     wr_in_g   = wr_input && hit;
      wire                     wr_gain_g = wr_gain && hit;
      wire                     wr_off_g  = wr_offset && hit;
      wire                     upd_g     = in_calc && (sel_ff == g);

      // outputs toward the string converters
      assign out_code_o[g*`DCCAL_CODE_W +: `DCCAL_CODE_W] = out_code_ff[g];
      assign ref_set2_o[g] = (g % `DCCAL_GROUP_SIZE) >= `DCCAL_GROUP_REF1;

      // input code, written by software
      always @*
      begin
        nxt_input = input_code_ff[g];
        if (wr_in_g)
          nxt_input = wdata_i[`DCCAL_CODE_W-1:0];
      end

      always @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          input_code_ff[g] <= `DCCAL_RST_INPUT;
        else
          input_code_ff[g] <= nxt_input;
      end

      // gain coefficient
      always @*
      begin
        nxt_gain = gain_ff[g];
        if (wr_gain_g)
          nxt_gain = wdata_i[`DCCAL_GAIN_W-1:0];
      end

      always @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          gain_ff[g] <= `DCCAL_RST_GAIN;
        else
          gain_ff[g] <= nxt_gain;
      end

      // offset coefficient
      always @*
      begin
        nxt_offset = offset_ff[g];
        if (wr_off_g)
          nxt_offset = wdata_i[`DCCAL_CODE_W-1:0];
      end

      always @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          offset_ff[g] <= `DCCAL_RST_OFFSET;
        else
          offset_ff[g] <= nxt_offset;
      end

      // converter code, written at the end of this channel's calculation
      always @*
      begin
        nxt_conv = converter_code_ff[g];
        if (upd_g)
          nxt_conv = clamped;
      end

      always @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          converter_code_ff[g] <= `DCCAL_RST_CONV;
        else
          converter_code_ff[g] <= nxt_conv;
      end

      // output code, copied from the converter code on a load
      always @*
      begin
        nxt_out = out_code_ff[g];
        if (copy_out)
          nxt_out = converter_code_ff[g];
      end

      always @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          out_code_ff[g] <= `DCCAL_RST_CONV;
        else
          out_code_ff[g] <= nxt_out;
      end
    end
  endgenerate

  // register read, data in the following cycle, zero otherwise
  always @*
  begin
    nxt_rdata = 16'h0000;
    if (rd_i)
    begin
      case (kind)
        `DCCAL_KIND_INPUT:
          nxt_rdata = {2'b00, input_code_ff[ch]};
        `DCCAL_KIND_GAIN:
          nxt_rdata = {3'b000, gain_ff[ch]};
        `DCCAL_KIND_OFFSET:
          nxt_rdata = {2'b00, offset_ff[ch]};
        `DCCAL_KIND_CONV:
          nxt_rdata = {2'b00, converter_code_ff[ch]};
        `DCCAL_KIND_OUT:
          nxt_rdata = {2'b00, out_code_ff[ch]};
        `DCCAL_KIND_STATUS:
          nxt_rdata = {15'h0000, busy};
        default:
          nxt_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 16'h0000;
    else
      rdata_o <= nxt_rdata;
  end

endmodule // dccal_datapath

// ### verification/dccal_datapath_chk.sv
// Purpose: port assertions for dccal_datapath
// Assumes: one clock, async active-low reset
// Notes:   bound after the module
`timescale 1ns/10ps
module dccal_datapath_chk #(parameter NUM_CH = 32)(
  // watched ports
  input wire                 mclk_i,
  input wire                 rst_n_i,
  input wire [7:0]           addr_i,
  input wire                 wr_i,
  input wire                 rd_i,
  input wire [15:0]          rdata_o,
  input wire                 load_outputs_n_i,
  input wire                 busy_n_o,
  input wire [NUM_CH*14-1:0] out_code_o,
  input wire [NUM_CH-1:0]    ref_set2_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_wb; wr_i && addr_i[7:5] < 3'h3 |=> !busy_n_o; endproperty
  a_wb: assert property (p_wb) else $error("no busy");
  property p_bd; $fell(busy_n_o) |-> ##[1:40] busy_n_o; endproperty
  a_bd: assert property (p_bd) else $error("busy stuck");
  property p_hold; !busy_n_o |=> $stable(out_code_o); endproperty
  a_hold: assert property (p_hold) else $error("update in busy");
  property p_nold; (load_outputs_n_i && busy_n_o) [*6] |=> $stable(out_code_o); endproperty
  a_nold: assert property (p_nold) else $error("update no load");
  property p_rz; !rd_i |=> rdata_o == 16'h0000; endproperty
  a_rz: assert property (p_rz) else $error("stray rdata");
  property p_ref; ref_set2_o == 32'hc0c0_c0c0; endproperty
  a_ref: assert property (p_ref) else $error("bad ref map");
  property p_st; rd_i && addr_i[7:5] == 3'h5 |=> rdata_o[0] == !$past(busy_n_o); endproperty
  a_st: assert property (p_st) else $error("bad status");
  property p_un; rd_i && addr_i[7:6] == 2'h3 |=> rdata_o == 16'h0000; endproperty
  a_un: assert property (p_un) else $error("unmapped nonzero");
  c_wr: cover property (wr_i && addr_i[7:5] == 3'h0);
  c_ld: cover property (!load_outputs_n_i && !busy_n_o);
  c_dn: cover property ($rose(busy_n_o));
endmodule // dccal_datapath_chk
bind dccal_datapath dccal_datapath_chk #(.NUM_CH(NUM_CH)) u_chk(.mclk_i, .rst_n_i, .addr_i, .wr_i, .rd_i,
  .rdata_o, .load_outputs_n_i, .busy_n_o, .out_code_o, .ref_set2_o);

// ### verification/dccal_datapath_test.sv
// Purpose: directed test of dccal_datapath
// Assumes: 50 MHz clock, 12-cycle reset
// Notes:   channel 3 carries most scenarios
`timescale 1ns/10ps
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module dccal_datapath_test;
  logic         mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, load_outputs_n_i = 1;
  logic [7:0]   addr_i = 0;
  logic [15:0]  wdata_i = 0, rdata_o;
  logic         busy_n_o;
  logic [447:0] out_code_o;
  logic [31:0]  ref_set2_o;
  int           miscompares = 0, total_checks = 0;
  dccal_datapath i_dut(.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .load_outputs_n_i,
    .busy_n_o, .out_code_o, .ref_set2_o);
  initial forever #10 mclk_i = ~mclk_i;
  task automatic wr(input [7:0] a, input [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 0;
  endtask
  task automatic rd(input [7:0] a, input [15:0] e);
    @(posedge mclk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 0;
    #1 `CHK("rdata_o", e, rdata_o)
  endtask
  task automatic idle;
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < 60 && busy_n_o !== 1'b1; i++) @(posedge mclk_i);
    #1 `CHK("busy_n_o", 1'b1, busy_n_o)
  endtask
  task automatic cal(input [15:0] x, m, c, e);
    wr(8'h03, x);
    wr(8'h23, m);
    wr(8'h43, c);
    #1 `CHK("busy_n_o", 1'b0, busy_n_o)
    idle;
    rd(8'h63, e);
  endtask
  task automatic t_reset;
    rd(8'h03, 16'h2000);
    rd(8'h25, 16'h1fff);
    rd(8'h5f, 16'h2000);
    rd(8'h67, 16'h2000);
  endtask
  task automatic t_calc;
    cal(16'h1000, 16'h0fff, 16'h2010, 16'h0810);
    cal(16'h0003, 16'h0fff, 16'h2000, 16'h0001);
    cal(16'h3fff, 16'h1fff, 16'h3fff, 16'h3fff);
    cal(16'h0000, 16'h1fff, 16'h0000, 16'h0000);
    rd(8'h24, 16'h1fff);
    `CHK("out_code_o", 14'h2000, out_code_o[55:42])
  endtask
  task automatic t_load;
    wr(8'h03, 16'h3000);
    load_outputs_n_i <= 0;
    @(posedge mclk_i);
    load_outputs_n_i <= 1;
    idle;
    repeat (4) @(posedge mclk_i);
    #1 `CHK("out_code_o", 14'h1000, out_code_o[55:42])
    rd(8'h83, 16'h1000);
  endtask
  task automatic t_refuse;
    wr(8'h63, 16'h0555);
    rd(8'h63, 16'h1000);
    rd(8'he0, 16'h0000);
    rd(8'ha0, 16'h0000);
  endtask
  task automatic t_defer;
    @(posedge mclk_i);
    wr_i <= 1;
    addr_i <= 8'h05;
    wdata_i <= 16'h3000;
    load_outputs_n_i <= 0;
    @(posedge mclk_i);
    wr_i <= 0;
    load_outputs_n_i <= 1;
    #1 `CHK("busy_n_o", 1'b0, busy_n_o)
    rd(8'ha0, 16'h0001);
    idle;
    repeat (2) @(posedge mclk_i);
    #1 `CHK("out_code_o", 14'h3000, out_code_o[83:70])
    `CHK("out_code_o", 14'h1000, out_code_o[55:42])
    `CHK("ref_set2_o", 32'hc0c0_c0c0, ref_set2_o)
  endtask
  task automatic t_hold;
    @(posedge mclk_i);
    load_outputs_n_i <= 0;
    wr(8'h03, 16'h2800);
    idle;
    repeat (3) @(posedge mclk_i);
    #1 `CHK("out_code_o", 14'h0800, out_code_o[55:42])
    @(posedge mclk_i);
    load_outputs_n_i <= 1;
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    summarize;
  end
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1;
    t_reset;
    t_calc;
    t_load;
    t_refuse;
    t_defer;
    t_hold;
    summarize;
  end
endmodule // dccal_datapath_test
